/* File: rtl/sinc_pkg.sv */
package sinc_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam longint unsigned MASTER_HZ = 4915200;
   localparam int unsigned OUT_PERIOD_MS = 200;
   localparam int unsigned DECIM_N_DEF = int'(MASTER_HZ * OUT_PERIOD_MS / 1000);
   localparam int unsigned ORDER = 4;
   localparam int unsigned SETTLE_WORDS = 4;
   localparam int unsigned HOST_WAIT_MS = SETTLE_WORDS * OUT_PERIOD_MS;
   // ****************************************
   // Scaling and layout
   // ****************************************
   localparam int unsigned OUT_W = 16;
   localparam int unsigned FIFO_DEPTH_DEF = 8;
   localparam int unsigned PRE_SHIFT_DEF = 48;
   localparam int unsigned NORM_SHIFT_DEF = 32;
   localparam logic [15:0] NORM_MUL_45 = 16'h7e6c;
   localparam logic [15:0] NORM_MUL_35 = 16'h0ca4;
   localparam logic SEL_RST = 1'b0;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ST_SETTLING = 2'b01,
      ST_SETTLED = 2'b10
   } filt_state_t;
   typedef struct packed {
      logic ext_clk;
      logic int_osc;
      logic mod_bit;
   } pins_t;
   typedef struct packed {
      logic signed [OUT_W-1:0] counts;
      logic settled;
   } result_t;
endpackage

/* File: rtl/res_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module res_fifo #(
   parameter int unsigned W = 17,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      if (push) begin
         wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; reads are guarded by the count
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   chk_fifo_full_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !in_ready && !out_ready |=> !in_ready)
      else $error("fifo lost a word while full");
endmodule // res_fifo
`default_nettype wire

/* File: rtl/sinc4_decimator_clock_select.sv */
`timescale 1ns/1ns
`default_nettype none
module sinc4_decimator_clock_select
   import sinc_pkg::*;
#(
   parameter int unsigned DECIM_N = sinc_pkg::DECIM_N_DEF,
   parameter int unsigned FIFO_DEPTH = sinc_pkg::FIFO_DEPTH_DEF,
   parameter int unsigned PRE_SHIFT = sinc_pkg::PRE_SHIFT_DEF,
   parameter int unsigned NORM_SHIFT = sinc_pkg::NORM_SHIFT_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins from oscillators and modulator
   input wire sinc_pkg::pins_t pins,
   // Configuration
   input wire logic clock_source_select,
   input wire logic digits_45,
   // Result stream
   output sinc_pkg::result_t res_data,
   output logic res_valid,
   input wire logic res_ready,
   // Status
   output logic eoc_n,
   output logic settled,
   output logic overrun
);
   import sinc_pkg::*;

   localparam int unsigned CNT_W = $clog2(DECIM_N);
   localparam int unsigned ACC_W = ORDER * CNT_W + 2;
   localparam int unsigned RES_W = $bits(result_t);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   pins_t s1_q, s2_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
      end
   end

   // ****************************************
   // Master clock select
   // ****************************************
   logic sel_q, sel_d, prev_q, prev_d;
   logic src_now, switching, tick;

   always_comb begin
      sel_d = clock_source_select;
      switching = sel_d != sel_q;
      src_now = sel_q ? s2_q.ext_clk : s2_q.int_osc;
      // Reload edge memory from the new source so the swap makes no edge
      prev_d = switching ? (sel_d ? s2_q.ext_clk : s2_q.int_osc) : src_now;
      tick = src_now && !prev_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_q <= SEL_RST;
         prev_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
         prev_q <= prev_d;
      end
   end

   // ****************************************
   // Sinc4 datapath
   // ****************************************
   logic signed [ACC_W-1:0] integ_q [ORDER];
   logic signed [ACC_W-1:0] integ_d [ORDER];
   logic signed [ACC_W-1:0] integ_src [ORDER];
   logic signed [ACC_W-1:0] dly_q [ORDER];
   logic signed [ACC_W-1:0] dly_d [ORDER];
   logic signed [ACC_W-1:0] comb_val [ORDER+1];
   logic signed [ACC_W-1:0] x, pre;
   logic signed [ACC_W+16:0] scaled;
   logic [CNT_W-1:0] dec_q, dec_d;
   logic dump;

   // Bit 1 means +1 and bit 0 means -1
   assign x = s2_q.mod_bit ? ACC_W'(1) : '1;
   assign comb_val[0] = integ_q[ORDER-1];

   for (genvar g = 0; g < ORDER; g++) begin : g_stage
      if (g == 0) begin : g_first
         assign integ_src[g] = x;
      end else begin : g_rest
         assign integ_src[g] = integ_q[g-1];
      end
      // Equal-length boxcars give zeros at every multiple of the rate
      assign comb_val[g+1] = comb_val[g] - dly_q[g];
   end

   always_comb begin
      dump = tick && (dec_q == CNT_W'(DECIM_N - 1));
      dec_d = dec_q;
      if (switching) begin
         dec_d = '0;
      end else if (dump) begin
         dec_d = '0;
      end else if (tick) begin
         dec_d = dec_q + CNT_W'(1);
      end
      for (int k = 0; k < ORDER; k++) begin
         integ_d[k] = integ_q[k];
         dly_d[k] = dly_q[k];
         if (switching) begin
            integ_d[k] = '0;
            dly_d[k] = '0;
         end else begin
            // Wraparound is harmless: the combs undo it exactly
            if (tick) begin
               integ_d[k] = integ_q[k] + integ_src[k];
            end
            if (dump) begin
               dly_d[k] = comb_val[k];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dec_q <= '0;
         for (int k = 0; k < ORDER; k++) begin
            integ_q[k] <= '0;
            dly_q[k] <= '0;
         end
      end else begin
         dec_q <= dec_d;
         for (int k = 0; k < ORDER; k++) begin
            integ_q[k] <= integ_d[k];
            dly_q[k] <= dly_d[k];
         end
      end
   end

   // Gain of N^4 removed by two shifts around a fixed multiply; count weight
   // per volt is set by the analog range, not here
   always_comb begin
      pre = comb_val[ORDER] >>> PRE_SHIFT;
      scaled = pre * $signed({1'b0, digits_45 ? NORM_MUL_45 : NORM_MUL_35});
      scaled = scaled >>> NORM_SHIFT;
   end

   // ****************************************
   // Settling and status
   // ****************************************
   filt_state_t state_q, state_d;
   logic [2:0] words_q, words_d;
   logic ovr_q, ovr_d;
   logic fifo_ready;
   result_t word;

   always_comb begin
      state_d = state_q;
      words_d = words_q;
      word.counts = scaled[OUT_W-1:0];
      word.settled = 1'b0;
      case (state_q)
         ST_SETTLING: begin
            if (dump) begin
               words_d = words_q + 3'd1;
               if (words_q == 3'(SETTLE_WORDS - 1)) begin
                  state_d = ST_SETTLED;
                  word.settled = 1'b1;
               end
            end
         end
         ST_SETTLED: begin
            word.settled = 1'b1;
         end
         default: begin
            state_d = ST_SETTLING;
         end
      endcase
      if (switching) begin
         state_d = ST_SETTLING;
         words_d = '0;
      end
      // Buffer full: the filter cannot wait, so the word is lost and flagged
      ovr_d = (dump && !fifo_ready) || (ovr_q && !switching);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_SETTLING;
         words_q <= '0;
         ovr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         words_q <= words_d;
         ovr_q <= ovr_d;
      end
   end

   res_fifo #(
      .W(RES_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(dump),
      .in_ready(fifo_ready),
      .in_data(word),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data)
   );

   assign eoc_n = !res_valid;
   assign settled = state_q == ST_SETTLED;
   assign overrun = ovr_q;

   // ****************************************
   // Checks
   // ****************************************
   chk_sel_reset_low: assert property (@(posedge clk) $rose(rst_n) |-> !sel_q)
      else $error("clock select not internal after reset");
   // Tick must be a real low-to-high step of the synced selected source
   chk_tick_source: assert property (@(posedge clk) disable iff (!rst_n)
      tick && !$past(switching) |-> (sel_q ? s2_q.ext_clk : s2_q.int_osc) &&
      !(sel_q ? $past(s2_q.ext_clk) : $past(s2_q.int_osc)))
      else $error("tick not from selected source edge");
   chk_switch_restart: assert property (@(posedge clk) disable iff (!rst_n)
      switching |=> integ_q[0] == '0 && words_q == '0 && state_q == ST_SETTLING && dec_q == '0)
      else $error("clock switch did not restart the filter");
   // Step taken at accumulator width so wraparound still reads as +1 or -1
   chk_integ_step: assert property (@(posedge clk) disable iff (!rst_n)
      tick && !switching |=> ACC_W'(integ_q[0] - $past(integ_q[0])) == ($past(s2_q.mod_bit) ? 1 : -1))
      else $error("first integrator step wrong");
   chk_dump_period: assert property (@(posedge clk) disable iff (!rst_n)
      dump |-> tick && dec_q == CNT_W'(DECIM_N - 1) ##1 dec_q == '0)
      else $error("output word not at end of decimation period");
   chk_settle_count: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_q == ST_SETTLED) |-> $past(dump) && $past(words_q) == 3'(SETTLE_WORDS - 1))
      else $error("settled before four output words");
   chk_overrun_set: assert property (@(posedge clk) disable iff (!rst_n)
      dump && !fifo_ready && !switching |=> overrun)
      else $error("dropped word not flagged");
   chk_eoc_fresh: assert property (@(posedge clk) disable iff (!rst_n)
      dump && fifo_ready |=> !eoc_n && res_valid)
      else $error("conversion done not asserted after store");
endmodule // sinc4_decimator_clock_select
`default_nettype wire

/* File: dv/mod_src.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Master clock sources and modulator stream
// ****************************************
module mod_src (
   // Run controls
   input wire logic int_run,
   input wire logic ext_run,
   // Pins
   output sinc_pkg::pins_t pins
);
   import sinc_pkg::*;
   logic int_c = 1'b0;
   logic ext_c = 1'b0;
   logic bit_q = 1'b0;
   integer seed = 9;
   // Stopped clocks park low, so no stray rising edge
   initial forever #50 int_c = int_run ? ~int_c : 1'b0;
   // External source at 5 MHz, inside its ceiling
   initial forever #100 ext_c = ext_run ? ~ext_c : 1'b0;
   // New bit on falling edges, stable around each rise
   always @(negedge int_c or negedge ext_c) bit_q = 1'($random(seed));
   assign pins = '{ext_clk: ext_c, int_osc: int_c, mod_bit: bit_q};
endmodule // mod_src
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import sinc_pkg::*;
   // ****************************************
   // Harness
   // ****************************************
   localparam int N = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sel = 1'b0;
   logic d45 = 1'b1;
   logic ready = 1'b0;
   logic int_run = 1'b0;
   logic ext_run = 1'b0;
   pins_t pins;
   result_t res;
   logic valid, eoc_n, settled, overrun;
   integer seed = 9;
   int miscompares = 0, n_compared = 0, cycles = 0, last = 0, gap = 0, nwords = 0, ticks = 0;
   longint integ[4], dly[4];
   result_t exp_q[$];
   initial forever #5 clk = ~clk;
   mod_src partner (.int_run(int_run), .ext_run(ext_run), .pins(pins));
   sinc4_decimator_clock_select #(.DECIM_N(N), .PRE_SHIFT(0), .NORM_SHIFT(0)) DUT (.clk(clk), .rst_n(rst_n),
      .pins(pins), .clock_source_select(sel), .digits_45(d45), .res_data(res), .res_valid(valid),
      .res_ready(ready), .eoc_n(eoc_n), .settled(settled), .overrun(overrun));
   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] expv);
      n_compared++;
      if (seen !== expv) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, expv, seen);
      end
   endtask
   task automatic close_out();
      if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****************************************
   // Reference filter, ideal cascade
   // ****************************************
   task automatic restart();
      for (int k = 0; k < 4; k++) begin
         integ[k] = 0;
         dly[k] = 0;
      end
      nwords = 0;
      ticks = 0;
      last = 0;
   endtask
   task automatic sample();
      longint c, y;
      // Word is taken from the last integrator as it stood before this tick
      if (++ticks == N) begin
         ticks = 0;
         c = integ[3];
         for (int k = 0; k < 4; k++) begin
            y = c - dly[k];
            dly[k] = c;
            c = y;
         end
         nwords++;
         // Full queue drops the word, as the buffer does
         if (exp_q.size() < FIFO_DEPTH_DEF) begin
            exp_q.push_back('{counts: 16'(c * (d45 ? NORM_MUL_45 : NORM_MUL_35)), settled: nwords >= SETTLE_WORDS});
         end
      end
      // Registered cascade: each stage adds its neighbour's previous value
      for (int k = 3; k > 0; k--) integ[k] += integ[k-1];
      integ[0] += pins.mod_bit ? 1 : -1;
   endtask
   // Only the selected source feeds the filter
   always @(posedge pins.int_osc) if (!sel) sample();
   always @(posedge pins.ext_clk) if (sel) sample();
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         close_out();
      end else if (rst_n) begin
         check("eoc_n", eoc_n, !valid);
         if (valid && ready) begin
            check("result word", res, exp_q[0]);
            void'(exp_q.pop_front());
            if (last != 0 && gap != 0) check("word spacing", 17'(cycles - last), 17'(gap));
            last = cycles;
         end
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic switch_to(input logic s, input logic d);
      int_run = 1'b0;
      ext_run = 1'b0;
      repeat (30) @(negedge clk);
      sel = s;
      d45 = d;
      repeat (3) @(negedge clk);
      restart();
      check("settled after switch", settled, 0);
      check("overrun after switch", overrun, 0);
   endtask
   task automatic run_words(input int n);
      if (sel) ext_run = 1'b1;
      else int_run = 1'b1;
      for (int i = 0; i < n * 200 && nwords < n; i++) @(negedge clk);
      repeat (10) @(negedge clk);
      // With the drain open every produced word must have come out
      if (ready) check("words left", 17'(exp_q.size()), 0);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      check("valid in reset", valid, 0);
      check("eoc_n in reset", eoc_n, 1);
      check("settled in reset", settled, 0);
      rst_n = 1'b1;
      restart();
      // Internal source from reset, drained at once
      ready = 1'b1;
      gap = 80;
      run_words(5);
      check("settled", settled, 1);
      // External selected but only the oscillator runs: nothing comes
      switch_to(1'b1, 1'b0);
      int_run = 1'b1;
      repeat (300) @(negedge clk);
      check("no word from unselected", valid, 0);
      int_run = 1'b0;
      gap = 160;
      run_words(6);
      check("settled on external", settled, 1);
      // Fill the buffer past full, then drain with stalls
      switch_to(1'b0, 1'b1);
      ready = 1'b0;
      gap = 0;
      run_words(11);
      int_run = 1'b0;
      repeat (20) @(negedge clk);
      check("overrun", overrun, 1);
      check("eoc_n while full", eoc_n, 0);
      for (int i = 0; i < 400 && exp_q.size() > 0; i++) begin
         @(negedge clk);
         ready = 1'($random(seed));
      end
      @(negedge clk);
      ready = 1'b1;
      check("valid after drain", valid, 0);
      check("overrun held", overrun, 1);
      switch_to(1'b1, 1'b1);
      close_out();
   end
endmodule // tb
`default_nettype wire
